/* File: hdl/pkh_host.sv */
`timescale 1ns/1ps
`default_nettype none

module pkh_host #(
    parameter int INHIBIT_CYCLES = pkh_pkg::INHIBIT_CYC,
    parameter int ACK_WAIT_CYCLES = pkh_pkg::ACK_WAIT_CYC
) (
    // System clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Port lines, split into input and open-drain enable
    input wire logic port_clock_line,
    input wire logic port_clock_in,
    output logic port_clock_oe,
    input wire logic port_data_in,
    output logic port_data_oe,
    // Configuration
    input wire logic mouse_mode,
    // Command request
    input wire logic cmd_valid,
    input wire pkh_pkg::pkh_op_t cmd_op,
    input wire logic [7:0] cmd_byte,
    output logic cmd_ready,
    output logic cmd_done,
    output logic cmd_fail,
    // Raw byte stream
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic frame_error,
    // Keyboard events
    output logic key_valid,
    output pkh_pkg::pkh_key_t key,
    // Mouse reports
    output logic mouse_valid,
    output pkh_pkg::pkh_mouse_t mouse
);
    typedef enum {
        S_IDLE, S_INHIBIT, S_RTS, S_SEND, S_ACK, S_ARG_WAIT
    } pkh_state_t;

    // ------------------------------------------------------------------
    // Crossing
    // ------------------------------------------------------------------
    logic [2:0] rx_sync;
    logic [2:0] tx_sync;
    logic link_rx_tgl;
    logic link_tx_tgl;
    logic [7:0] link_byte;
    logic link_bad;
    logic tx_arm;
    logic link_data_oe;
    logic [7:0] tx_shadow;
    logic [1:0] clk_pin_sync;

    pkh_link u_link (
        .link_clk(port_clock_line),
        .sys_rst(sys_rst),
        .data_in(port_data_in),
        .data_oe(link_data_oe),
        .tx_arm(tx_arm),
        .tx_byte(tx_shadow),
        .rx_byte(link_byte),
        .rx_bad(link_bad),
        .rx_tgl(link_rx_tgl),
        .tx_tgl(link_tx_tgl)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_sync <= 3'h0;
            tx_sync <= 3'h0;
            clk_pin_sync <= 2'h3;
        end else begin
            rx_sync <= {rx_sync[1:0], link_rx_tgl};
            tx_sync <= {tx_sync[1:0], link_tx_tgl};
            clk_pin_sync <= {clk_pin_sync[0], port_clock_in};
        end
    end

    // The byte and flag are stable long before the toggle is seen.
    wire rx_evt = rx_sync[2] ^ rx_sync[1];
    wire tx_evt = tx_sync[2] ^ tx_sync[1];
    wire rx_ok = rx_evt && !link_bad;
    wire clk_seen_low = !clk_pin_sync[1];

    // ------------------------------------------------------------------
    // Receive decode
    // ------------------------------------------------------------------
    logic pend_rel;
    logic pend_ext;
    logic [1:0] pkt_idx;
    logic [7:0] pkt_stat;
    logic [7:0] pkt_x;
    logic waiting_ack;

    wire is_rel = link_byte == pkh_pkg::BYTE_RELEASE;
    wire is_ext = link_byte == pkh_pkg::BYTE_EXTEND;
    wire is_ack = link_byte == pkh_pkg::BYTE_ACK;
    wire prefix = is_rel || is_ext;
    wire kb_rx = rx_ok && !mouse_mode && !waiting_ack;
    wire pkt_last = pkt_idx == 2'(pkh_pkg::PKT_BYTES - 1);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
            frame_error <= 1'b0;
        end else begin
            byte_valid <= rx_ok;
            frame_error <= rx_evt && link_bad;
            if (rx_ok) begin
                byte_data <= link_byte;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_rel <= 1'b0;
            pend_ext <= 1'b0;
            key_valid <= 1'b0;
            key <= '0;
        end else begin
            key_valid <= kb_rx && !prefix;
            if (kb_rx) begin
                if (is_ext) begin
                    pend_ext <= 1'b1;
                end else if (is_rel) begin
                    pend_rel <= 1'b1;
                end else begin
                    // Codes are passed through untranslated.
                    key <= '{released: pend_rel, extended: pend_ext,
                             code: link_byte};
                    pend_rel <= 1'b0;
                    pend_ext <= 1'b0;
                end
            end
        end
    end

    // A bad frame restarts packet alignment.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pkt_idx <= 2'h0;
            pkt_stat <= 8'h00;
            pkt_x <= 8'h00;
            mouse_valid <= 1'b0;
            mouse <= '0;
        end else begin
            mouse_valid <= rx_ok && mouse_mode && pkt_last;
            if (!mouse_mode || (rx_evt && link_bad)) begin
                pkt_idx <= 2'h0;
            end else if (rx_ok) begin
                pkt_idx <= pkt_last ? 2'h0 : pkt_idx + 2'h1;
                if (pkt_idx == 2'h0) begin
                    pkt_stat <= link_byte;
                end
                if (pkt_idx == 2'h1) begin
                    pkt_x <= link_byte;
                end
                if (pkt_last) begin
                    mouse <= '{
                        left: pkt_stat[pkh_pkg::POS_LEFT],
                        right: pkt_stat[pkh_pkg::POS_RIGHT],
                        horiz_sign_bit: pkt_stat[pkh_pkg::POS_XSIGN],
                        vert_sign_bit: pkt_stat[pkh_pkg::POS_YSIGN],
                        horiz_overflow_bit: pkt_stat[pkh_pkg::POS_XOVF],
                        vert_overflow_bit: pkt_stat[pkh_pkg::POS_YOVF],
                        // Sign extends to 9 bits.
                        dx: {pkt_stat[pkh_pkg::POS_XSIGN], pkt_x},
                        dy: {pkt_stat[pkh_pkg::POS_YSIGN], link_byte}
                    };
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit sequencer
    // ------------------------------------------------------------------
    pkh_state_t state;
    pkh_state_t next_state;
    logic [19:0] timer;
    logic [7:0] arg;
    logic two_byte;

    assign waiting_ack = state == S_ACK;
    assign cmd_ready = state == S_IDLE;
    assign tx_arm = state == S_RTS || state == S_SEND;
    // Clock held low inhibits the peripheral.
    assign port_clock_oe = state == S_INHIBIT;
    // The link holds data low for the start bit once armed, so the
    // release of the clock and the first data bit need no handover.
    assign port_data_oe = state == S_INHIBIT || link_data_oe;
    wire timeout = timer == 20'(ACK_WAIT_CYCLES);
    wire is_arg_op = cmd_op != pkh_pkg::PKH_OP_RAW;

    always_comb begin
        next_state = state;
        unique case (state)
            S_IDLE: if (cmd_valid) next_state = S_INHIBIT;
            S_INHIBIT: if (timer == 20'(INHIBIT_CYCLES)) next_state = S_RTS;
            S_RTS: begin
                // A fast peripheral may finish before the low clock is seen.
                if (tx_evt) begin
                    next_state = S_ACK;
                end else if (clk_seen_low) begin
                    next_state = S_SEND;
                end
            end
            S_SEND: if (tx_evt) next_state = S_ACK;
            S_ACK: if (rx_evt || timeout) next_state = S_IDLE;
            S_ARG_WAIT: next_state = S_INHIBIT;
        endcase
        if (state == S_ACK && rx_ok && is_ack && two_byte) begin
            next_state = S_ARG_WAIT;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_IDLE;
            timer <= 20'h0;
            tx_shadow <= 8'h00;
            arg <= 8'h00;
            two_byte <= 1'b0;
            cmd_done <= 1'b0;
            cmd_fail <= 1'b0;
        end else begin
            state <= next_state;
            timer <= (next_state != state) ? 20'h0 : timer + 20'h1;
            cmd_done <= state == S_ACK && next_state == S_IDLE && rx_ok;
            cmd_fail <= state == S_ACK && next_state == S_IDLE && !rx_ok;
            if (state == S_IDLE && cmd_valid) begin
                two_byte <= is_arg_op;
                arg <= cmd_byte;
                unique case (cmd_op)
                    pkh_pkg::PKH_OP_LEDS: tx_shadow <= pkh_pkg::CMD_LEDS;
                    pkh_pkg::PKH_OP_RATE: tx_shadow <= pkh_pkg::CMD_RATE;
                    default: tx_shadow <= cmd_byte;
                endcase
            end else if (state == S_ARG_WAIT) begin
                two_byte <= 1'b0;
                tx_shadow <= arg;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_clock_low_only_inhibit;
        @(posedge clk) disable iff (sys_rst)
        port_clock_oe |-> state == S_INHIBIT && port_data_oe;
    endproperty
    a_clock_low_only_inhibit: assert property (p_clock_low_only_inhibit)
        else $error("clock driven outside inhibit");

    property p_release_sets_flag;
        @(posedge clk) disable iff (sys_rst)
        kb_rx && is_rel |=> pend_rel;
    endproperty
    a_release_sets_flag: assert property (p_release_sets_flag)
        else $error("release prefix lost");

    property p_key_after_ext;
        @(posedge clk) disable iff (sys_rst)
        kb_rx && !prefix && pend_ext |=> key_valid && key.extended;
    endproperty
    a_key_after_ext: assert property (p_key_after_ext)
        else $error("extended key not flagged");

    property p_bad_no_byte;
        @(posedge clk) disable iff (sys_rst)
        rx_evt && link_bad |=> frame_error && !byte_valid && !key_valid;
    endproperty
    a_bad_no_byte: assert property (p_bad_no_byte)
        else $error("bad frame passed on");

    property p_arg_after_ack;
        @(posedge clk) disable iff (sys_rst)
        state == S_ACK && rx_ok && is_ack && two_byte
            |=> state == S_ARG_WAIT ##1 state == S_INHIBIT;
    endproperty
    a_arg_after_ack: assert property (p_arg_after_ack)
        else $error("argument not sent after ack");

    property p_rate_opcode;
        @(posedge clk) disable iff (sys_rst)
        state == S_IDLE && cmd_valid && cmd_op == pkh_pkg::PKH_OP_RATE
            |=> tx_shadow == pkh_pkg::CMD_RATE && two_byte;
    endproperty
    a_rate_opcode: assert property (p_rate_opcode)
        else $error("rate command byte wrong");

    property p_mouse_sign;
        @(posedge clk) disable iff (sys_rst)
        mouse_valid |-> mouse.dx[8] == mouse.horiz_sign_bit
            && mouse.dy[8] == mouse.vert_sign_bit;
    endproperty
    a_mouse_sign: assert property (p_mouse_sign)
        else $error("mouse sign mismatch");

    property p_mouse_three;
        @(posedge clk) disable iff (sys_rst)
        mouse_valid |-> $past(pkt_idx) == 2'h2;
    endproperty
    a_mouse_three: assert property (p_mouse_three)
        else $error("mouse report not on third byte");

endmodule : pkh_host

`default_nettype wire

/* File: hdl/pkh_pkg.sv */
package pkh_pkg;

    // ------------------------------------------------------------------
    // Protocol bytes
    // ------------------------------------------------------------------
    localparam logic [7:0] BYTE_RELEASE = 8'hf0;
    localparam logic [7:0] BYTE_EXTEND = 8'he0;
    localparam logic [7:0] BYTE_ACK = 8'hfa;
    localparam logic [7:0] CMD_LEDS = 8'hed;
    localparam logic [7:0] CMD_ECHO = 8'hee;
    localparam logic [7:0] CMD_RATE = 8'hf3;
    localparam logic [7:0] CMD_RESEND = 8'hfe;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int FRAME_BITS = 11;
    localparam int PKT_BYTES = 3;
    localparam int POS_LEFT = 0;
    localparam int POS_RIGHT = 1;
    localparam int POS_XSIGN = 4;
    localparam int POS_YSIGN = 5;
    localparam int POS_XOVF = 6;
    localparam int POS_YOVF = 7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int INHIBIT_US = 100;
    localparam int INHIBIT_CYC = (INHIBIT_US * (CLK_HZ / 1000000));
    localparam int RTS_US = 10;
    localparam int RTS_CYC = (RTS_US * (CLK_HZ / 1000000));
    localparam int ACK_WAIT_MS = 20;
    localparam int ACK_WAIT_CYC = ACK_WAIT_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic released;
        logic extended;
        logic [7:0] code;
    } pkh_key_t;

    typedef struct packed {
        logic left;
        logic right;
        logic horiz_sign_bit;
        logic vert_sign_bit;
        logic horiz_overflow_bit;
        logic vert_overflow_bit;
        logic [8:0] dx;
        logic [8:0] dy;
    } pkh_mouse_t;

    typedef enum logic [1:0] {
        PKH_OP_RAW,
        PKH_OP_LEDS,
        PKH_OP_RATE
    } pkh_op_t;

endpackage : pkh_pkg

/* File: hdl/pkh_link.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Link-clock side: shifts frames in on falling clock and out while low
// ----------------------------------------------------------------------
// Clocked by the port clock line, so it only moves during frames and on the host's inhibit edge.
module pkh_link (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic sys_rst,
    // Data line
    input wire logic data_in,
    output logic data_oe,
    // Transmit side, held stable by the system domain while tx_arm is set
    input wire logic tx_arm,
    input wire logic [7:0] tx_byte,
    // Results, event toggles toward the system domain
    output logic [7:0] rx_byte,
    output logic rx_bad,
    output logic rx_tgl,
    output logic tx_tgl
);
    logic [10:0] shreg;
    logic [3:0] cnt;
    logic txing;
    logic tx_fin;
    logic [9:0] tx_sh;
    logic [3:0] tx_cnt;

    // Falling edge of clock samples data; a transmit frame also ends on a falling edge.
    always_ff @(negedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shreg <= 11'h000;
            cnt <= 4'h0;
            rx_byte <= 8'h00;
            rx_bad <= 1'b0;
            rx_tgl <= 1'b0;
        end else if (!tx_arm) begin
            shreg <= {data_in, shreg[10:1]};
            if (cnt == 4'(pkh_pkg::FRAME_BITS - 1)) begin
                cnt <= 4'h0;
                rx_byte <= shreg[9:2];
                // Odd parity over data+parity, zero start, one stop.
                rx_bad <= !(^{shreg[10:2]}) || shreg[1] || !data_in;
                rx_tgl <= ~rx_tgl;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end else begin
            // The inhibit edge and the host's own frame are not received.
            cnt <= 4'h0;
        end
    end

    // Bits change while clock is low, after the falling edge. The done
    // flag keeps the line released until the system side disarms.
    always_ff @(negedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txing <= 1'b0;
            tx_fin <= 1'b0;
            tx_sh <= 10'h3ff;
            tx_cnt <= 4'h0;
            tx_tgl <= 1'b0;
        end else if (!tx_arm) begin
            txing <= 1'b0;
            tx_fin <= 1'b0;
        end else if (!txing && !tx_fin) begin
            txing <= 1'b1;
            tx_sh <= {1'b1, ~(^tx_byte), tx_byte};
            tx_cnt <= 4'h0;
        end else if (txing) begin
            tx_sh <= {1'b1, tx_sh[9:1]};
            tx_cnt <= tx_cnt + 4'h1;
            // The eleventh falling edge carries the peripheral's ack bit.
            if (tx_cnt == 4'(pkh_pkg::FRAME_BITS - 2)) begin
                txing <= 1'b0;
                tx_fin <= 1'b1;
                tx_tgl <= ~tx_tgl;
            end
        end
    end

    // Armed and not yet clocked, the line carries the start bit; later
    // it is pulled low only for zero bits, ones are left to the pull-up.
    assign data_oe = tx_arm && !tx_fin &&
        (!txing || (tx_cnt < 4'h9 && !tx_sh[0]));

endmodule : pkh_link

`default_nettype wire

/* File: testbench/pkh_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none

// --------------------
// Peripheral model
// --------------------
// Phases are 3 ns instead of tens of microseconds to keep the run short.
module pkh_dev_model (
    // Sensed wire levels
    input wire logic clk_w,
    input wire logic data_w,
    // Pull-down enables, the model never drives a line high
    output logic clk_low,
    output logic data_low
);
    logic [7:0] sent[$];
    logic [9:0] rxq[$];
    logic [7:0] last = 8'h00;
    logic [2:0] leds = 3'h0;
    logic mute = 1'b0;
    logic led_next = 1'b0;
    logic busy = 1'b0;
    logic [9:0] sh;

    initial begin
        clk_low = 1'b0;
        data_low = 1'b0;
    end

    // Bad is 0 for a good frame, 1 for wrong parity, 2 for wrong stop.
    task automatic send(input logic [7:0] b, input int bad);
        logic [10:0] f;
        f = {bad != 2, (~^b) ^ (bad == 1), b, 1'b0};
        wait (clk_w && data_w);
        busy = 1'b1;
        for (int i = 0; i < 11; i++) begin
            data_low = !f[i];
            #1.5 clk_low = 1'b1;
            #3 clk_low = 1'b0;
            #1.5;
        end
        data_low = 1'b0;
        busy = 1'b0;
        if (bad == 0) sent.push_back(b);
        if (bad == 0 && b != pkh_pkg::BYTE_ACK) last = b;
        #300;
    endtask : send

    task automatic reply(input logic [7:0] b);
        #400;
        if (!mute) begin
            if (led_next) leds = b[2:0];
            led_next = (b == pkh_pkg::CMD_LEDS);
            if (b == pkh_pkg::CMD_ECHO) send(b, 0);
            else if (b == pkh_pkg::CMD_RESEND) send(last, 0);
            else send(pkh_pkg::BYTE_ACK, 0);
        end
    endtask : reply

    // A host request is a clock pulled low by the host, then released
    // with data held low.
    always begin
        // Own frames are skipped: the wire lags the pull-down by a delta.
        wait (clk_w == 1'b0 && !clk_low && !busy);
        wait (clk_w == 1'b1);
        #1;
        if (data_w == 1'b0) begin
            #2;
            for (int k = 0; k < 11; k++) begin
                #1.5 clk_low = 1'b1;
                #3 clk_low = 1'b0;
                if (k < 10) sh[k] = data_w;
                if (k == 9) data_low = 1'b1;
                #1.5;
            end
            data_low = 1'b0;
            rxq.push_back(sh);
            reply(sh[7:0]);
        end
    end
endmodule : pkh_dev_model

`default_nettype wire

/* File: testbench/ps2_keyboard_mouse_host_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module ps2_keyboard_mouse_host_tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b0;
    logic mouse_mode = 1'b0;
    logic cmd_valid = 1'b0;
    pkh_pkg::pkh_op_t cmd_op = pkh_pkg::PKH_OP_RAW;
    logic [7:0] cmd_byte = 8'h00;
    logic clk_oe, data_oe, dclk_low, ddata_low;
    logic cmd_ready, cmd_done, cmd_fail, byte_valid, frame_error;
    logic key_valid, mouse_valid;
    logic [7:0] byte_data;
    pkh_pkg::pkh_key_t key;
    pkh_pkg::pkh_mouse_t mouse;
    wire logic line_clk = !(clk_oe || dclk_low);
    wire logic line_data = !(data_oe || ddata_low);
    logic [31:0] expq[$];
    logic [7:0] txb[7] = '{8'hed, 8'h05, 8'hf3, 8'h2a, 8'hfe, 8'hee, 8'hf4};
    logic [7:0] st, x, y;
    logic [7:0] exp_byte;
    int mismatches = 0;
    int checks = 0;
    logic [7:0] rnd = 8'h38;

    always #10 clk = ~clk;

    pkh_host #(.INHIBIT_CYCLES(20), .ACK_WAIT_CYCLES(2000)) u_pkh_host (
        .clk(clk), .sys_rst(sys_rst),
        .port_clock_line(line_clk), .port_clock_in(line_clk),
        .port_clock_oe(clk_oe), .port_data_in(line_data),
        .port_data_oe(data_oe), .mouse_mode(mouse_mode),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_byte(cmd_byte),
        .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_fail(cmd_fail),
        .byte_valid(byte_valid), .byte_data(byte_data),
        .frame_error(frame_error), .key_valid(key_valid), .key(key),
        .mouse_valid(mouse_valid), .mouse(mouse)
    );

    pkh_dev_model u_pkh_dev_model (
        .clk_w(line_clk), .data_w(line_data),
        .clk_low(dclk_low), .data_low(ddata_low)
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic pop_cmp(input string n, input logic [31:0] g);
        logic [31:0] e;
        e = (expq.size() > 0) ? expq.pop_front() : 32'hxxxxxxxx;
        `CHK(n, e, g)
    endtask : pop_cmp

    // --------------------
    // Result watcher
    // --------------------
    always @(negedge clk) begin
        if (key_valid) pop_cmp("key", {4'h1, 18'h0, key});
        if (mouse_valid) begin
            pop_cmp("mouse", {8'h20, mouse});
        end
        if (frame_error) pop_cmp("frame_error", 32'h30000000);
        if (cmd_done) pop_cmp("cmd_done", 32'h40000000);
        if (cmd_fail) pop_cmp("cmd_fail", 32'h50000000);
        if (byte_valid) begin
            exp_byte = (u_pkh_dev_model.sent.size() > 0) ?
                u_pkh_dev_model.sent.pop_front() : 8'hxx;
            `CHK("byte", exp_byte, byte_data)
        end
    end

    // Mode bit 1 is a release, bit 0 an extended key.
    task automatic key_evt(input int m, input logic [7:0] c);
        expq.push_back({4'h1, 18'h0, m[1], m[0], c});
        if (m[0]) u_pkh_dev_model.send(pkh_pkg::BYTE_EXTEND, 0);
        if (m[1]) u_pkh_dev_model.send(pkh_pkg::BYTE_RELEASE, 0);
        u_pkh_dev_model.send(c, 0);
    endtask : key_evt

    task automatic cmd(input pkh_pkg::pkh_op_t op, input logic [7:0] b,
                       input logic [31:0] e);
        int n;
        n = 0;
        expq.push_back(e);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_byte = b;
        @(negedge clk);
        cmd_valid = 1'b0;
        while (expq.size() > 0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        if (n == 5000) mismatches++;
        #600;
    endtask : cmd

    initial begin
        #400000;
        mismatches++;
        test_done();
    end

    initial begin
        // A reset edge is needed: the link side has no clock to reset on.
        #1 sys_rst = 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        #200;
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            key_evt(i % 4, {1'b0, rnd[6:0]});
        end
        key_evt(0, 8'h1c);
        key_evt(0, 8'h1c);
        for (int b = 1; b < 3; b++) begin
            expq.push_back(32'h30000000);
            u_pkh_dev_model.send(8'h2b, b);
        end
        key_evt(2, 8'h2b);
        cmd(pkh_pkg::PKH_OP_LEDS, 8'h05, 32'h40000000);
        `CHK("leds", 3'b101, u_pkh_dev_model.leds)
        cmd(pkh_pkg::PKH_OP_RATE, 8'h2a, 32'h40000000);
        cmd(pkh_pkg::PKH_OP_RAW, 8'hfe, 32'h40000000);
        cmd(pkh_pkg::PKH_OP_RAW, 8'hee, 32'h40000000);
        u_pkh_dev_model.mute = 1'b1;
        cmd(pkh_pkg::PKH_OP_RAW, 8'hf4, 32'h50000000);
        u_pkh_dev_model.mute = 1'b0;
        foreach (txb[i]) begin
            `CHK("tx", {1'b1, ~^txb[i], txb[i]}, u_pkh_dev_model.rxq[i])
        end
        @(negedge clk) mouse_mode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            st = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd;
            x = lfsr(rnd);
            y = lfsr(x);
            rnd = y;
            expq.push_back({8'h20, st[0], st[1], st[4], st[5], st[6], st[7],
                st[4], x, st[5], y});
            u_pkh_dev_model.send(st, 0);
            u_pkh_dev_model.send(x, 0);
            u_pkh_dev_model.send(y, 0);
        end
        #1000;
        `CHK("pending", 0, expq.size())
        test_done();
    end
endmodule : ps2_keyboard_mouse_host_tb_top

`default_nettype wire
